// ===== design/bcp_compare.sv
// Buffered dual-edge and center-aligned PWM compare with AXI4-Lite registers.
// Assumes count_tick is a one-cycle pulse from the prescaled count clock
// and restart_in is the external restart source, both synchronous to clk_sys.
//
// Summary of operation
// - Select 0101 gives buffered dual-edge compare output
// - Edge writes go to holding buffers first
// - Buffered dual-edge uses 16 bits, ignores wide select
// - Restart to zero copies buffers to active edges
// - Wrap from FFFFh copies buffers to active edges
// - Module off: edge writes reach active registers directly
// - Count low counter, bounded by period; buffers next period
// - Select 0110 gives center-aligned PWM output
// - Self-synchronized center mode uses period register
// - Rising value is total width, centered on half-period
// - Center mode uses 16 bits, ignores wide select
// - Falling value serves as trigger time in center mode
// - Dedicated 16-bit adder/subtracter computes center edges
// - Period double-buffered, reloaded on rollover or restart
// - Upper 15 period bits form center reference
// - Rise at half-period minus half-width
// - After rise, fall at half-period plus half-width
// - Width buffered, edges always use buffered width
// - Low on entry, rise match high, fall match low+flag
// - Odd width LSB widens falling edge only
// - Width above period plus one gives no pulses
// - Trigger value match issues special event trigger
`default_nettype none
module bcp_compare #(
  parameter int unsigned TW = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire bcp_pkg::bcp_axil_req_t s_axi_req,
  output var  bcp_pkg::bcp_axil_rsp_t s_axi_rsp,
  input  wire logic                   count_tick,
  input  wire logic                   restart_in,
  output logic                        compare_output_pin,
  output logic                        trigger_pulse
);
  import bcp_pkg::*;

  // Edge logic is built for a 16-bit time base only
  if (TW != 16) begin : g_chk
    $error("bcp_compare: TW must be 16");
  end

  // Bus handshake state
  logic            awready_r;
  logic            wready_r;
  logic            bvalid_r;
  logic            arready_r;
  logic            rvalid_r;
  logic            aw_full_r;
  logic            w_full_r;
  logic [AW-1:0]   awaddr_r;
  logic [DW-1:0]   wdata_r;
  logic [3:0]      wstrb_r;
  logic [1:0]      bresp_r;
  logic [1:0]      rresp_r;
  logic [DW-1:0]   rdata_r;
  logic            aw_take;
  logic            w_take;
  logic            ar_take;
  logic            do_write;
  logic            aw_full_nxt;
  logic            w_full_nxt;
  logic            bvalid_nxt;
  logic            rvalid_nxt;

  // Block registers
  logic            on_r;
  logic [3:0]      operating_select_field_r;
  logic            wide_timer_select_r;
  logic            self_sync_r;
  logic [TW-1:0]   counter_low_r;
  logic [TW-1:0]   period_low_value_r;
  logic [TW-1:0]   period_value_r;
  logic [TW-1:0]   rise_buf_r, fall_buf_r;
  logic [TW-1:0]   rising_or_width_value_r;
  logic [TW-1:0]   falling_or_trigger_value_r;
  logic            compare_event_flag_r, timer_event_flag_r, trig_flag_r;
  logic            out_r, trig_r;
  logic [3:0]      mode_seen_r;

  // Datapath
  logic            wr_ctrl;
  logic            wr_status;
  logic            wr_counter;
  logic            wr_period;
  logic            wr_rise;
  logic            wr_fall;
  logic            mode_dual;
  logic            mode_center;
  logic            active;
  logic            per_match;
  logic            ext_rst;
  logic            wrap;
  logic            reload;
  logic [TW:0]     rise_t;
  logic [TW:0]     fall_t;
  logic [TW:0]     width_lim;
  logic [TW-2:0]   half_per;
  logic [TW-2:0]   half_wid;
  logic            no_pulse;
  logic            match_r;
  logic            match_f;
  logic            match_t;
  logic            fall_evt;
  logic            rise_evt;
  logic [DW-1:0]   rd_val;
  logic            rd_ok;
  logic            wr_ok;

  function automatic logic [TW-1:0] merge16(input logic [TW-1:0] old,
                                            input logic [DW-1:0] d,
                                            input logic [3:0]    s);
    logic [TW-1:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction : merge16

  // Write channel handshake, address and data in either order
  always_comb begin
    aw_take     = s_axi_req.awvalid & awready_r;
    w_take      = s_axi_req.wvalid & wready_r;
    do_write    = aw_full_r & w_full_r & ~bvalid_r;
    aw_full_nxt = (aw_full_r & ~do_write) | aw_take;
    w_full_nxt  = (w_full_r & ~do_write) | w_take;
    bvalid_nxt  = do_write | (bvalid_r & ~s_axi_req.bready);
    ar_take     = s_axi_req.arvalid & arready_r;
    rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_req.rready);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      bvalid_r  <= bvalid_nxt;
      awready_r <= ~aw_full_nxt & ~bvalid_nxt;
      wready_r  <= ~w_full_nxt & ~bvalid_nxt;
      if (aw_take) begin
        awaddr_r <= s_axi_req.awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_req.wdata;
        wstrb_r <= s_axi_req.wstrb;
      end
      if (do_write) begin
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel, data captured at address acceptance
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      rvalid_r  <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_rsp = '{awready: awready_r, wready: wready_r,
                       bvalid: bvalid_r, bresp: bresp_r,
                       arready: arready_r, rvalid: rvalid_r,
                       rdata: rdata_r, rresp: rresp_r};

  // Address decode
  always_comb begin
    wr_ctrl    = do_write && awaddr_r == OFS_CTRL;
    wr_status  = do_write && awaddr_r == OFS_STATUS;
    wr_counter = do_write && awaddr_r == OFS_COUNTER;
    wr_period  = do_write && awaddr_r == OFS_PERIOD;
    wr_rise    = do_write && awaddr_r == OFS_RISE;
    wr_fall    = do_write && awaddr_r == OFS_FALL;
    wr_ok = awaddr_r <= OFS_FALL && awaddr_r[1:0] == 2'h0;
    rd_ok = 1'b1;
    rd_val = '0;
    unique case (s_axi_req.araddr)
      OFS_CTRL: begin
        rd_val[CTRL_ON_BIT] = on_r;
        rd_val[CTRL_MODE_LSB +: 4] = operating_select_field_r;
        rd_val[CTRL_WIDE_BIT] = wide_timer_select_r;
        rd_val[CTRL_SYNC_BIT] = self_sync_r;
      end
      OFS_STATUS: begin
        rd_val[ST_CMP_BIT] = compare_event_flag_r;
        rd_val[ST_TMR_BIT] = timer_event_flag_r;
        rd_val[ST_TRG_BIT] = trig_flag_r;
        rd_val[ST_OUT_BIT] = out_r;
      end
      OFS_COUNTER: rd_val[TW-1:0] = counter_low_r;
      OFS_PERIOD:  rd_val[TW-1:0] = period_low_value_r;
      OFS_RISE:    rd_val[TW-1:0] = rise_buf_r;
      OFS_FALL:    rd_val[TW-1:0] = fall_buf_r;
      OFS_ACT_EDG: rd_val = {falling_or_trigger_value_r,
                             rising_or_width_value_r};
      OFS_ACT_PER: rd_val[TW-1:0] = period_value_r;
      default:     rd_ok = 1'b0;
    endcase
  end

  // Control register; wide select stored but never used
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      on_r                     <= 1'b0;
      operating_select_field_r <= 4'h0;
      wide_timer_select_r      <= 1'b0;
      self_sync_r              <= 1'b0;
    end else if (wr_ctrl && wstrb_r[0]) begin
      on_r                     <= wdata_r[CTRL_ON_BIT];
      operating_select_field_r <= wdata_r[CTRL_MODE_LSB +: 4];
      wide_timer_select_r      <= wdata_r[CTRL_WIDE_BIT];
      self_sync_r              <= wdata_r[CTRL_SYNC_BIT];
    end
  end

  // Mode decode and time base
  always_comb begin
    mode_dual   = operating_select_field_r == MODE_DUAL_BUF;
    mode_center = operating_select_field_r == MODE_CENTER;
    active      = on_r & (mode_dual | mode_center) &
                  mode_seen_r == operating_select_field_r;
    per_match   = self_sync_r & counter_low_r == period_value_r;
    ext_rst     = ~self_sync_r & restart_in;
    wrap        = counter_low_r == CNT_TOP;
    reload      = on_r & count_tick & (per_match | ext_rst | wrap);
  end

  // Counter: runs while on, software may preset it while off
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      counter_low_r <= RST_VALUE;
    end else if (!on_r) begin
      if (wr_counter) begin
        counter_low_r <= merge16(counter_low_r, wdata_r, wstrb_r);
      end
    end else if (count_tick) begin
      counter_low_r <= (per_match | ext_rst | wrap) ? RST_VALUE
                       : counter_low_r + 16'h0001;
    end
  end

  // Holding buffers written by software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_low_value_r <= RST_PERIOD;
      rise_buf_r         <= RST_VALUE;
      fall_buf_r         <= RST_VALUE;
    end else begin
      if (wr_period) begin
        period_low_value_r <= merge16(period_low_value_r, wdata_r, wstrb_r);
      end
      if (wr_rise) begin
        rise_buf_r <= merge16(rise_buf_r, wdata_r, wstrb_r);
      end
      if (wr_fall) begin
        fall_buf_r <= merge16(fall_buf_r, wdata_r, wstrb_r);
      end
    end
  end

  // Active compare registers: transparent while off, else at reload; period also tracks its buffer every cycle outside center mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rising_or_width_value_r    <= RST_VALUE;
      falling_or_trigger_value_r <= RST_VALUE;
      period_value_r             <= RST_PERIOD;
    end else if (!on_r) begin
      rising_or_width_value_r    <= rise_buf_r;
      falling_or_trigger_value_r <= fall_buf_r;
      period_value_r             <= period_low_value_r;
    end else begin
      if (reload) begin
        rising_or_width_value_r    <= rise_buf_r;
        falling_or_trigger_value_r <= fall_buf_r;
      end
      if (reload || !mode_center) begin
        period_value_r <= period_low_value_r;
      end
    end
  end

  // Center-aligned edge arithmetic
  always_comb begin
    half_per  = period_value_r[TW-1:1];
    half_wid  = rising_or_width_value_r[TW-1:1];
    rise_t    = {2'b00, half_per} - {2'b00, half_wid};
    fall_t    = {2'b00, half_per} + {2'b00, half_wid}
                + {{TW{1'b0}}, rising_or_width_value_r[0]};
    width_lim = {1'b0, period_value_r} + 17'h00001;
    no_pulse  = ({1'b0, rising_or_width_value_r} > width_lim)
                | rise_t[TW];
    if (mode_center) begin
      match_r = ~no_pulse & {1'b0, counter_low_r} == rise_t;
      match_f = ~no_pulse & {1'b0, counter_low_r} == fall_t;
    end else begin
      match_r = counter_low_r == rising_or_width_value_r;
      match_f = counter_low_r == falling_or_trigger_value_r;
    end
    match_t  = mode_center &
               counter_low_r == falling_or_trigger_value_r;
    fall_evt = active & count_tick & match_f & (out_r | match_r);
    rise_evt = active & count_tick & match_r & ~match_f;
  end

  // Output pin; low on entry, falling match wins over rising
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_seen_r <= 4'h0;
      out_r       <= 1'b0;
    end else begin
      mode_seen_r <= on_r ? operating_select_field_r : 4'h0;
      if (!active) begin
        out_r <= 1'b0;
      end else if (fall_evt) begin
        out_r <= 1'b0;
      end else if (rise_evt) begin
        out_r <= 1'b1;
      end
    end
  end

  // Special event trigger pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= active & count_tick & match_t;
    end
  end

  // Sticky status flags, write one to clear, set wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      compare_event_flag_r <= 1'b0;
      timer_event_flag_r   <= 1'b0;
      trig_flag_r          <= 1'b0;
    end else begin
      compare_event_flag_r <= (fall_evt & out_r) | (compare_event_flag_r &
        ~(wr_status & wstrb_r[0] & wdata_r[ST_CMP_BIT]));
      timer_event_flag_r <= (active & reload) | (timer_event_flag_r &
        ~(wr_status & wstrb_r[0] & wdata_r[ST_TMR_BIT]));
      trig_flag_r <= (active & count_tick & match_t) | (trig_flag_r &
        ~(wr_status & wstrb_r[0] & wdata_r[ST_TRG_BIT]));
    end
  end

  assign compare_output_pin = out_r;
  assign trigger_pulse      = trig_r;
endmodule : bcp_compare
`default_nettype wire

// ===== design/bcp_pkg.sv
// Shared constants and bus carrier types of the buffered PWM compare block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
`default_nettype none
package bcp_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS  = 8'h04;
  localparam logic [AW-1:0] OFS_COUNTER = 8'h08;
  localparam logic [AW-1:0] OFS_PERIOD  = 8'h0c;
  localparam logic [AW-1:0] OFS_RISE    = 8'h10;
  localparam logic [AW-1:0] OFS_FALL    = 8'h14;
  localparam logic [AW-1:0] OFS_ACT_EDG = 8'h18;
  localparam logic [AW-1:0] OFS_ACT_PER = 8'h1c;

  // Control field positions
  localparam int unsigned CTRL_ON_BIT   = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_WIDE_BIT = 5;
  localparam int unsigned CTRL_SYNC_BIT = 6;

  // Status field positions
  localparam int unsigned ST_CMP_BIT  = 0;
  localparam int unsigned ST_TMR_BIT  = 1;
  localparam int unsigned ST_TRG_BIT  = 2;
  localparam int unsigned ST_OUT_BIT  = 3;

  // Operating select codes
  localparam logic [3:0] MODE_DUAL_BUF = 4'h5;
  localparam logic [3:0] MODE_CENTER   = 4'h6;

  // Reset values and counter wrap value
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_VALUE  = 16'h0000;
  localparam logic [15:0] CNT_TOP    = 16'hffff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [DW-1:0] wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } bcp_axil_req_t;

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [DW-1:0] rdata;
    logic [1:0]    rresp;
  } bcp_axil_rsp_t;
endpackage : bcp_pkg
`default_nettype wire

// ===== sim/bcp_compare_sva.sv
// Protocol and PWM timing checks on the compare block's ports.
// Assumes one clock domain and an active-low asynchronous reset.
`default_nettype none
module bcp_compare_sva #(
  parameter int unsigned TW = 16
) (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire bcp_pkg::bcp_axil_req_t s_axi_req,
  input wire bcp_pkg::bcp_axil_rsp_t s_axi_rsp,
  input wire logic                   count_tick,
  input wire logic                   restart_in,
  input wire logic                   compare_output_pin,
  input wire logic                   trigger_pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  import bcp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_bvalid_hold: assert property (s_axi_rsp.bvalid && !s_axi_req.bready
    |=> s_axi_rsp.bvalid && $stable(s_axi_rsp.bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rsp.rvalid && !s_axi_req.rready
    |=> s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_req.arvalid && s_axi_rsp.arready
    |=> s_axi_rsp.rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_req.awvalid && s_axi_rsp.awready
    && s_axi_req.wvalid && s_axi_rsp.wready |-> ##[1:2] s_axi_rsp.bvalid)
    else $error("write answer late");
  a_ar_refused: assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (s_axi_rsp.bvalid
    |-> !s_axi_rsp.awready && !s_axi_rsp.wready)
    else $error("write taken while answer pending");
  a_trig_on_tick: assert property (trigger_pulse |-> $past(count_tick))
    else $error("trigger without count tick");
  a_trig_single: assert property (trigger_pulse |=> !trigger_pulse)
    else $error("trigger longer than one cycle");
  a_rise_on_tick: assert property ($rose(compare_output_pin)
    |-> $past(count_tick))
    else $error("output rose without count tick");

  c_trigger: cover property (trigger_pulse);
  c_rise: cover property ($rose(compare_output_pin));
  c_fall: cover property ($fell(compare_output_pin));
  c_write: cover property (s_axi_rsp.bvalid && s_axi_req.bready);
endmodule : bcp_compare_sva

bind bcp_compare bcp_compare_sva #(.TW(TW)) sva_u (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_req(s_axi_req),
  .s_axi_rsp(s_axi_rsp), .count_tick(count_tick), .restart_in(restart_in),
  .compare_output_pin(compare_output_pin), .trigger_pulse(trigger_pulse));
`default_nettype wire

// ===== sim/bcp_load_model.sv
// Power load fed by the PWM pin; measures the width of each pulse.
// Assumes one count per system clock, pin sampled on the rising edge.
`default_nettype none
module bcp_load_model (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        pwm_in,
  output logic      [15:0] last_width
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] run_r;
  logic        prev_r;
  // On-time of the last completed pulse
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r      <= 16'h0;
      prev_r     <= 1'b0;
      last_width <= 16'h0;
    end else begin
      prev_r <= pwm_in;
      run_r  <= pwm_in ? run_r + 16'h1 : 16'h0;
      if (prev_r && !pwm_in) last_width <= run_r;
    end
  end
endmodule : bcp_load_model
`default_nettype wire

// ===== sim/testbench.sv
// Register-driven tests of the buffered dual-edge and center PWM block.
// Assumes one count tick per clock while ticking, bus at 40 MHz.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import bcp_pkg::*;
  logic          clk_sys = 1'b0;
  logic          rstn, tick, rst_src, pin, trig;
  bcp_axil_req_t req;
  bcp_axil_rsp_t rsp;
  logic [15:0]   width;
  int            err_count, n_compared, h, t0;
  int            trig_n = 0;

  always #12.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (trig === 1'b1) trig_n <= trig_n + 1;

  bcp_compare #(.TW(16)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .s_axi_req(req), .s_axi_rsp(rsp), .count_tick(tick),
    .restart_in(rst_src), .compare_output_pin(pin), .trigger_pulse(trig));
  bcp_load_model load_u (.clk_sys(clk_sys), .rstn(rstn), .pwm_in(pin),
    .last_width(width));

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic timeout;
    err_count++;
    $display("unexpected bus wait: expected answer seen none");
    close_out();
  endtask : timeout

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic       ah, wh, bh;
    logic [1:0] r;
    int         n;
    n = 0;
    bh = 1'b0;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (bh !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      ah = req.awvalid & rsp.awready;
      wh = req.wvalid & rsp.wready;
      bh = rsp.bvalid;
      r  = rsp.bresp;
      @(posedge clk_sys);
      if (ah) req.awvalid <= 1'b0;
      if (wh) req.wvalid <= 1'b0;
      n++;
    end
    if (bh !== 1'b1) timeout();
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e,
                        input logic [1:0] er);
    logic        ah, rh;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    rh = 1'b0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    while (rh !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      ah = req.arvalid & rsp.arready;
      rh = rsp.rvalid;
      d  = rsp.rdata;
      r  = rsp.rresp;
      @(posedge clk_sys);
      if (ah) req.arvalid <= 1'b0;
      n++;
    end
    if (rh !== 1'b1) timeout();
    chk("rresp", {30'h0, r}, {30'h0, er});
    if (er == RESP_OKAY) chk("rdata", d & m, e);
  endtask : rd_chk

  task automatic tick_once(input logic rs);
    tick    <= 1'b1;
    rst_src <= rs;
    @(posedge clk_sys);
    tick    <= 1'b0;
    rst_src <= 1'b0;
  endtask : tick_once

  task automatic hi_count(output int hn);
    hn = 0;
    repeat (21) begin
      @(negedge clk_sys);
      if (pin === 1'b1) hn++;
    end
    @(posedge clk_sys);
  endtask : hi_count

  initial begin
    rstn = 1'b0;
    req = '0;
    tick = 1'b1;
    rst_src = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_chk(OFS_ACT_PER, 32'hffffffff, 32'h0000ffff, RESP_OKAY);
    rd_chk(8'h20, 32'h0, 32'h0, RESP_SLVERR);
    wr(OFS_ACT_EDG, 32'h1, RESP_SLVERR);
    wr(OFS_RISE, 32'h3, RESP_OKAY);
    wr(OFS_FALL, 32'h9, RESP_OKAY);
    rd_chk(OFS_ACT_EDG, 32'hffffffff, 32'h00090003, RESP_OKAY);
    wr(OFS_PERIOD, 32'h13, RESP_OKAY);
    wr(OFS_CTRL, 32'h6b, RESP_OKAY);
    repeat (60) @(posedge clk_sys);
    chk("width", {16'h0, width}, 32'h6);
    rd_chk(OFS_STATUS, 32'h3, 32'h3, RESP_OKAY);
    tick <= 1'b0;
    wr(OFS_RISE, 32'h2, RESP_OKAY);
    wr(OFS_FALL, 32'hc, RESP_OKAY);
    rd_chk(OFS_ACT_EDG, 32'hffffffff, 32'h00090003, RESP_OKAY);
    tick <= 1'b1;
    repeat (60) @(posedge clk_sys);
    rd_chk(OFS_ACT_EDG, 32'hffffffff, 32'h000c0002, RESP_OKAY);
    chk("width", {16'h0, width}, 32'ha);
    tick <= 1'b0;
    wr(OFS_CTRL, 32'h0b, RESP_OKAY);
    wr(OFS_RISE, 32'h1, RESP_OKAY);
    wr(OFS_FALL, 32'h5, RESP_OKAY);
    tick_once(1'b1);
    rd_chk(OFS_ACT_EDG, 32'hffffffff, 32'h00050001, RESP_OKAY);
    rd_chk(OFS_COUNTER, 32'hffff, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h0a, RESP_OKAY);
    wr(OFS_COUNTER, 32'hffff, RESP_OKAY);
    wr(OFS_CTRL, 32'h0b, RESP_OKAY);
    wr(OFS_RISE, 32'h0, RESP_OKAY);
    wr(OFS_FALL, 32'h4, RESP_OKAY);
    rd_chk(OFS_ACT_EDG, 32'hffffffff, 32'h00050001, RESP_OKAY);
    tick_once(1'b0);
    rd_chk(OFS_ACT_EDG, 32'hffffffff, 32'h00040000, RESP_OKAY);
    wr(OFS_CTRL, 32'h6d, RESP_OKAY);
    wr(OFS_PERIOD, 32'h14, RESP_OKAY);
    rd_chk(OFS_ACT_PER, 32'hffff, 32'h13, RESP_OKAY);
    wr(OFS_RISE, 32'h6, RESP_OKAY);
    wr(OFS_FALL, 32'h5, RESP_OKAY);
    rd_chk(OFS_ACT_EDG, 32'hffff, 32'h0, RESP_OKAY);
    tick <= 1'b1;
    repeat (70) @(posedge clk_sys);
    rd_chk(OFS_ACT_PER, 32'hffff, 32'h14, RESP_OKAY);
    chk("width", {16'h0, width}, 32'h6);
    wr(OFS_RISE, 32'h7, RESP_OKAY);
    repeat (70) @(posedge clk_sys);
    chk("width", {16'h0, width}, 32'h7);
    t0 = trig_n;
    repeat (63) @(posedge clk_sys);
    chk("triggers", trig_n - t0, 32'h3);
    wr(OFS_RISE, 32'h16, RESP_OKAY);
    repeat (45) @(posedge clk_sys);
    hi_count(h);
    chk("high count", h, 32'h0);
    wr(OFS_RISE, 32'h15, RESP_OKAY);
    repeat (45) @(posedge clk_sys);
    hi_count(h);
    chk("high count", h, 32'h15);
    tick <= 1'b0;
    rd_chk(OFS_STATUS, 32'hf, 32'hf, RESP_OKAY);
    wr(OFS_STATUS, 32'h7, RESP_OKAY);
    rd_chk(OFS_STATUS, 32'hf, 32'h8, RESP_OKAY);
    close_out();
  end
endmodule : testbench
`default_nettype wire
